// File: hdl/video_decoder_control_regs.sv
// Decoder control register bank with its serial host port and pin control
//
// Summary of operation
// [RQ1] Two-bit field selects control pin function
// [RQ2] Vertical blank output gated by on/off bit
// [RQ3] Sync-lock input forces clocks and syncs nominal
// [RQ4] One bit swaps indicator pin sources
// [RQ5] Pixel buses driven only when three enables agree
// [RQ6] Sync and active-video outputs follow enable bit
// [RQ7] Clock outputs follow clock enable bit
// [RQ8] Two-bit color killer mode field
// [RQ9] Burst compared with five-bit killer threshold
// [RQ10] Pedestal bit selects assumed input pedestal
// [RQ11] Blanking bypass disables filters, zeroes color
// [RQ12] Signed four-bit luma to chroma delay
// [RQ13] Luma filter select with automatic fallback
// [RQ14] Two-bit luma coring threshold
// [RQ15] Two-bit luma peaking gain
// [RQ16] Two-bit peaking center frequency code
// [RQ17] Eight-bit brightness, reset mid-scale
// [RQ18] Eight-bit saturation, reset mid-scale
// [RQ19] Signed eight-bit hue rotation
// [RQ20] Eight-bit contrast, reset mid-scale
// [RQ21] Signed line offsets move blanking start, end
// [RQ22] Reserved bits read zero, writes ignored
`default_nettype none
module video_decoder_control_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic general_purpose_control_pin_i,
  output logic general_purpose_control_pin_o,
  output logic general_purpose_control_pin_oe_o,
  output logic force_nominal_o,
  input wire logic [9:0] line_num_i,
  input wire logic [9:0] vbi_first_line_i,
  input wire logic [9:0] vbi_last_line_i,
  input wire logic pal_flag_i,
  input wire logic field_id_i,
  input wire logic horizontal_lock_flag_i,
  input wire logic vertical_lock_flag_i,
  output logic pal_standard_flag_pin_o,
  output logic field_identifier_pin_o,
  input wire logic output_enable_pin_n_i,
  input wire logic yuv_enable_ext_i,
  input wire vdec_ctrl_pkg::pixel_s pix_i,
  input wire logic pix_valid_i,
  output logic [7:0] luma_output_bus_o,
  output logic [7:0] chroma_output_bus_o,
  output logic yuv_oe_o,
  output logic sync_oe_o,
  output logic clock_oe_o,
  input wire logic [4:0] burst_level_i,
  input wire logic sync_unstable_i,
  output vdec_ctrl_pkg::proc_settings_s settings_o
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_SUB = 4'h2,
    ST_SUB_ACK = 4'h6,
    ST_WDATA = 4'h7,
    ST_WDATA_ACK = 4'h5,
    ST_RDATA = 4'h4,
    ST_RDATA_ACK = 4'hc
  } host_state_e;

  logic [7:0] regs_q [vdec_ctrl_pkg::NUM_REGS];
  logic scl_s1_q, scl_s2_q, scl_d_q;
  logic sda_s1_q, sda_s2_q, sda_d_q;
  logic general_purpose_control_pin_s1_q, general_purpose_control_pin_s2_q;
  logic oen_s1_q, oen_s2_q;
  logic start_det, stop_det, scl_rise, scl_fall;
  host_state_e state_q;
  logic [2:0] bitcnt_q;
  logic [7:0] shift_q;
  logic [7:0] sub_q;
  logic rw_q, nack_q, sda_low_q;
  logic wr_q;
  logic [7:0] wr_addr_q, wr_data_q;
  logic [7:0] rd_data;
  logic [7:0] misc, kill, luma1, luma2;
  vdec_ctrl_pkg::general_purpose_control_pin_mode_e general_purpose_control_pin_mode;
  vdec_ctrl_pkg::killer_e kill_mode;
  vdec_ctrl_pkg::luma_filter_e filt_sel;
  logic signed [11:0] line_s, vb_start, vb_end;
  logic vblank_q, bypass_act;
  logic general_purpose_control_pin_out_q;
  logic pal_standard_flag_pin_q, fid_q;
  vdec_ctrl_pkg::pixel_s dly_q [vdec_ctrl_pkg::DLY_DEPTH];
  logic [3:0] luma_tap;
  logic kill_act, trap_sel;
  logic [7:0] luma_q, chroma_q;

  // Pins from outside the clock domain pass two flip-flops first
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_d_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_d_q <= 1'b1;
      general_purpose_control_pin_s1_q <= 1'b0;
      general_purpose_control_pin_s2_q <= 1'b0;
      oen_s1_q <= 1'b1;
      oen_s2_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_i;
      scl_s2_q <= scl_s1_q;
      scl_d_q <= scl_s2_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
      sda_d_q <= sda_s2_q;
      general_purpose_control_pin_s1_q <= general_purpose_control_pin_i;
      general_purpose_control_pin_s2_q <= general_purpose_control_pin_s1_q;
      oen_s1_q <= output_enable_pin_n_i;
      oen_s2_q <= oen_s1_q;
    end
  end

  assign start_det = scl_s2_q & scl_d_q & sda_d_q & ~sda_s2_q;
  assign stop_det = scl_s2_q & scl_d_q & ~sda_d_q & sda_s2_q;
  assign scl_rise = scl_s2_q & ~scl_d_q;
  assign scl_fall = ~scl_s2_q & scl_d_q;

  // Serial host port: device address, sub-address, then data with auto-increment
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      bitcnt_q <= 3'h0;
      shift_q <= 8'h00;
      sub_q <= 8'h00;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      sda_low_q <= 1'b0;
      wr_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_q <= 1'b0;
      if (stop_det) begin
        state_q <= ST_IDLE;
        sda_low_q <= 1'b0;
      end else if (start_det) begin
        state_q <= ST_ADDR;
        bitcnt_q <= 3'h0;
        sda_low_q <= 1'b0;
      end else begin
        case (state_q)
          ST_ADDR, ST_SUB, ST_WDATA: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_s2_q};
              bitcnt_q <= bitcnt_q + 3'h1;
              if (bitcnt_q == 3'h7) begin
                if (state_q == ST_ADDR) begin
                  rw_q <= sda_s2_q;
                  // A foreign address leaves the bus alone until the next start
                  state_q <= (shift_q[6:0] == DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
                end else if (state_q == ST_SUB) begin
                  sub_q <= {shift_q[6:0], sda_s2_q};
                  state_q <= ST_SUB_ACK;
                end else begin
                  wr_q <= 1'b1;
                  wr_addr_q <= sub_q;
                  wr_data_q <= {shift_q[6:0], sda_s2_q};
                  sub_q <= sub_q + 8'h01;
                  state_q <= ST_WDATA_ACK;
                end
              end
            end
          end
          ST_ADDR_ACK, ST_SUB_ACK, ST_WDATA_ACK: begin
            if (scl_fall) begin
              if (!sda_low_q) begin
                sda_low_q <= 1'b1;
              end else begin
                bitcnt_q <= 3'h0;
                if (state_q == ST_ADDR_ACK && rw_q) begin
                  shift_q <= rd_data;
                  sda_low_q <= ~rd_data[7];
                  sub_q <= sub_q + 8'h01;
                  state_q <= ST_RDATA;
                end else begin
                  sda_low_q <= 1'b0;
                  state_q <= (state_q == ST_ADDR_ACK) ? ST_SUB : ST_WDATA;
                end
              end
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              if (bitcnt_q == 3'h7) begin
                sda_low_q <= 1'b0;
                state_q <= ST_RDATA_ACK;
              end else begin
                shift_q <= {shift_q[6:0], 1'b0};
                sda_low_q <= ~shift_q[6];
                bitcnt_q <= bitcnt_q + 3'h1;
              end
            end
          end
          ST_RDATA_ACK: begin
            if (scl_rise) begin
              nack_q <= sda_s2_q;
            end else if (scl_fall) begin
              if (nack_q) begin
                state_q <= ST_IDLE;
              end else begin
                shift_q <= rd_data;
                sda_low_q <= ~rd_data[7];
                sub_q <= sub_q + 8'h01;
                bitcnt_q <= 3'h0;
                state_q <= ST_RDATA;
              end
            end
          end
          default: begin
            sda_low_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Open-drain data line: only ever pulled low
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_low_q;

  // Register storage, one entry per mapped offset
  genvar g;
  generate
    for (g = 0; g < vdec_ctrl_pkg::NUM_REGS; g++) begin : g_reg
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          regs_q[g] <= vdec_ctrl_pkg::REG_RST[g];
        end else if (wr_q && wr_addr_q == vdec_ctrl_pkg::REG_OFS[g]) begin
          regs_q[g] <= wr_data_q & vdec_ctrl_pkg::REG_MASK[g]; // RQ22
        end
      end
    end
  endgenerate

  // Unmapped sub-addresses read as zero
  always_comb begin
    rd_data = vdec_ctrl_pkg::UNMAPPED_READ;
    for (int i = 0; i < vdec_ctrl_pkg::NUM_REGS; i++) begin
      if (sub_q == vdec_ctrl_pkg::REG_OFS[i]) begin
        rd_data = regs_q[i]; // RQ22
      end
    end
  end

  assign misc = regs_q[vdec_ctrl_pkg::IDX_MISC];
  assign kill = regs_q[vdec_ctrl_pkg::IDX_KILL];
  assign luma1 = regs_q[vdec_ctrl_pkg::IDX_LUMA1];
  assign luma2 = regs_q[vdec_ctrl_pkg::IDX_LUMA2];
  assign general_purpose_control_pin_mode = vdec_ctrl_pkg::general_purpose_control_pin_mode_e'(misc[vdec_ctrl_pkg::MISC_GENERAL_PURPOSE_CONTROL_PIN_LO +: 2]);
  assign kill_mode = vdec_ctrl_pkg::killer_e'(kill[vdec_ctrl_pkg::KILL_MODE_LO +: 2]);
  assign filt_sel = vdec_ctrl_pkg::luma_filter_e'(luma2[vdec_ctrl_pkg::L2_FILT_LO +: 2]);

  // Blanking window moved by signed line offsets on both edges
  assign line_s = {2'b00, line_num_i};
  assign vb_start = {2'b00, vbi_first_line_i} +
                    {{4{regs_q[vdec_ctrl_pkg::IDX_VBLK_START][7]}},
                     regs_q[vdec_ctrl_pkg::IDX_VBLK_START]}; // RQ21
  assign vb_end = {2'b00, vbi_last_line_i} +
                  {{4{regs_q[vdec_ctrl_pkg::IDX_VBLK_END][7]}},
                   regs_q[vdec_ctrl_pkg::IDX_VBLK_END]}; // RQ21

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vblank_q <= 1'b0;
    end else begin
      vblank_q <= (line_s >= vb_start) && (line_s <= vb_end); // RQ21
    end
  end

  // Control pin driver
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      general_purpose_control_pin_out_q <= 1'b0;
    end else begin
      case (general_purpose_control_pin_mode)
        vdec_ctrl_pkg::GENERAL_PURPOSE_CONTROL_PIN_LOW: general_purpose_control_pin_out_q <= 1'b0; // RQ1
        vdec_ctrl_pkg::GENERAL_PURPOSE_CONTROL_PIN_HIGH: general_purpose_control_pin_out_q <= 1'b1; // RQ1
        vdec_ctrl_pkg::GENERAL_PURPOSE_CONTROL_PIN_VBLANK: begin
          general_purpose_control_pin_out_q <= vblank_q & misc[vdec_ctrl_pkg::MISC_VBLK_ON]; // RQ2
        end
        default: general_purpose_control_pin_out_q <= 1'b0;
      endcase
    end
  end

  assign general_purpose_control_pin_o = general_purpose_control_pin_out_q;
  assign general_purpose_control_pin_oe_o = (general_purpose_control_pin_mode != vdec_ctrl_pkg::GENERAL_PURPOSE_CONTROL_PIN_SYNC_LOCK); // RQ1
  // Lock request is active high and only heard while the pin is an input
  assign force_nominal_o = (general_purpose_control_pin_mode == vdec_ctrl_pkg::GENERAL_PURPOSE_CONTROL_PIN_SYNC_LOCK) & general_purpose_control_pin_s2_q; // RQ3

  // Indicator pins
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pal_standard_flag_pin_q <= 1'b0;
      fid_q <= 1'b0;
    end else if (misc[vdec_ctrl_pkg::MISC_IND_SEL]) begin
      pal_standard_flag_pin_q <= horizontal_lock_flag_i; // RQ4
      fid_q <= vertical_lock_flag_i; // RQ4
    end else begin
      pal_standard_flag_pin_q <= pal_flag_i; // RQ4
      fid_q <= field_id_i; // RQ4
    end
  end

  assign pal_standard_flag_pin_o = pal_standard_flag_pin_q;
  assign field_identifier_pin_o = fid_q;

  // Output enables
  assign yuv_oe_o = ~oen_s2_q & misc[vdec_ctrl_pkg::MISC_YUV_EN] & yuv_enable_ext_i; // RQ5
  assign sync_oe_o = misc[vdec_ctrl_pkg::MISC_SYNC_EN]; // RQ6
  assign clock_oe_o = misc[vdec_ctrl_pkg::MISC_CLK_EN]; // RQ7

  // Pixel delay line; chroma taps the centre so luma can lead or lag
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dly_q[0] <= '0;
    end else if (pix_valid_i) begin
      dly_q[0] <= pix_i;
    end
  end

  generate
    for (g = 1; g < vdec_ctrl_pkg::DLY_DEPTH; g++) begin : g_dly
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          dly_q[g] <= '0;
        end else if (pix_valid_i) begin
          dly_q[g] <= dly_q[g-1];
        end
      end
    end
  endgenerate

  // Negative codes: top bit set, magnitude is the low bits plus one
  assign luma_tap = luma1[vdec_ctrl_pkg::L1_DLY_HI] ?
                    vdec_ctrl_pkg::DLY_CENTER - {1'b0, luma1[2:0]} - 4'h1 :
                    vdec_ctrl_pkg::DLY_CENTER + {1'b0, luma1[2:0]}; // RQ12

  assign bypass_act = luma1[vdec_ctrl_pkg::L1_BYPASS] & vblank_q; // RQ11

  always_comb begin
    case (kill_mode)
      vdec_ctrl_pkg::KILL_AUTO: begin
        kill_act = burst_level_i < kill[vdec_ctrl_pkg::KILL_THR_HI:0]; // RQ9
      end
      vdec_ctrl_pkg::KILL_FORCE: kill_act = 1'b1; // RQ8
      default: kill_act = 1'b0; // RQ8
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      luma_q <= 8'h00;
      chroma_q <= vdec_ctrl_pkg::ZERO_CHROMA;
    end else if (pix_valid_i) begin
      luma_q <= dly_q[luma_tap].luma; // RQ12
      if (kill_act || bypass_act) begin
        chroma_q <= vdec_ctrl_pkg::ZERO_CHROMA; // RQ8 RQ11
      end else begin
        chroma_q <= dly_q[vdec_ctrl_pkg::DLY_CENTER].chroma;
      end
    end
  end

  assign luma_output_bus_o = luma_q;
  assign chroma_output_bus_o = chroma_q;

  // Automatic filter choice falls back to the trap on PAL or shaky syncs
  always_comb begin
    case (filt_sel)
      vdec_ctrl_pkg::LF_TRAP: trap_sel = 1'b1; // RQ13
      vdec_ctrl_pkg::LF_COMB: trap_sel = 1'b0; // RQ13
      default: trap_sel = sync_unstable_i | pal_flag_i; // RQ13
    endcase
  end

  always_comb begin
    settings_o.pedestal_absent = luma1[vdec_ctrl_pkg::L1_PEDESTAL]; // RQ10
    settings_o.notch_on = trap_sel & ~bypass_act; // RQ11
    settings_o.comb_on = ~trap_sel & ~bypass_act; // RQ11
    settings_o.coring = luma2[vdec_ctrl_pkg::L2_CORE_LO +: 2]; // RQ14
    settings_o.peak_gain = luma2[vdec_ctrl_pkg::L2_GAIN_LO +: 2]; // RQ15
    settings_o.peak_freq = luma2[vdec_ctrl_pkg::L2_FREQ_LO +: 2]; // RQ16
    settings_o.brightness = regs_q[vdec_ctrl_pkg::IDX_BRIGHT]; // RQ17
    settings_o.saturation = regs_q[vdec_ctrl_pkg::IDX_SAT]; // RQ18
    settings_o.hue = regs_q[vdec_ctrl_pkg::IDX_HUE]; // RQ19
    settings_o.contrast = regs_q[vdec_ctrl_pkg::IDX_CONTRAST]; // RQ20
  end

endmodule
`default_nettype wire

// File: inc/vdec_ctrl_pkg.sv
// Constants and types shared by the decoder control register bank
`default_nettype none
package vdec_ctrl_pkg;
  localparam int NUM_REGS = 10;
  localparam int IDX_MISC = 0;
  localparam int IDX_KILL = 1;
  localparam int IDX_LUMA1 = 2;
  localparam int IDX_LUMA2 = 3;
  localparam int IDX_BRIGHT = 4;
  localparam int IDX_SAT = 5;
  localparam int IDX_HUE = 6;
  localparam int IDX_CONTRAST = 7;
  localparam int IDX_VBLK_START = 8;
  localparam int IDX_VBLK_END = 9;
  localparam logic [7:0] REG_OFS [NUM_REGS] = '{8'h03, 8'h06, 8'h07, 8'h08, 8'h09,
                                               8'h0a, 8'h0b, 8'h0c, 8'h18, 8'h19};
  localparam logic [7:0] REG_RST [NUM_REGS] = '{8'h01, 8'h10, 8'h00, 8'h00, 8'h80,
                                               8'h80, 8'h00, 8'h80, 8'h00, 8'h00};
  localparam logic [7:0] REG_MASK [NUM_REGS] = '{8'hfb, 8'h7f, 8'h5f, 8'hff, 8'hff,
                                                8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  localparam int MISC_GENERAL_PURPOSE_CONTROL_PIN_LO = 6;
  localparam int MISC_IND_SEL = 5;
  localparam int MISC_YUV_EN = 4;
  localparam int MISC_SYNC_EN = 3;
  localparam int MISC_VBLK_ON = 1;
  localparam int MISC_CLK_EN = 0;
  localparam int KILL_MODE_LO = 5;
  localparam int KILL_THR_HI = 4;
  localparam int L1_PEDESTAL = 6;
  localparam int L1_BYPASS = 4;
  localparam int L1_DLY_HI = 3;
  localparam int L2_FILT_LO = 6;
  localparam int L2_CORE_LO = 4;
  localparam int L2_GAIN_LO = 2;
  localparam int L2_FREQ_LO = 0;
  localparam int DLY_DEPTH = 16;
  localparam logic [3:0] DLY_CENTER = 4'h8;
  localparam logic [7:0] ZERO_CHROMA = 8'h80;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  typedef enum logic [1:0] {
    GENERAL_PURPOSE_CONTROL_PIN_LOW = 2'h0, GENERAL_PURPOSE_CONTROL_PIN_HIGH = 2'h1, GENERAL_PURPOSE_CONTROL_PIN_VBLANK = 2'h2, GENERAL_PURPOSE_CONTROL_PIN_SYNC_LOCK = 2'h3
  } general_purpose_control_pin_mode_e;
  typedef enum logic [1:0] {
    KILL_AUTO = 2'h0, KILL_RSVD = 2'h1, KILL_FORCE = 2'h2, KILL_OFF = 2'h3
  } killer_e;
  typedef enum logic [1:0] {
    LF_AUTO = 2'h0, LF_RSVD = 2'h1, LF_TRAP = 2'h2, LF_COMB = 2'h3
  } luma_filter_e;
  typedef struct packed {
    logic [7:0] luma;
    logic [7:0] chroma;
  } pixel_s;
  typedef struct packed {
    logic pedestal_absent;
    logic notch_on;
    logic comb_on;
    logic [1:0] coring;
    logic [1:0] peak_gain;
    logic [1:0] peak_freq;
    logic [7:0] brightness;
    logic [7:0] saturation;
    logic [7:0] hue;
    logic [7:0] contrast;
  } proc_settings_s;
endpackage
`default_nettype wire

// File: test/tb.sv
// Self-checking bench for the decoder control register bank
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, nrst_i = 0, gp_pin = 0, pal = 0, field_identifier_pin = 0, horizontal_lock_flag = 0, vertical_lock_flag = 0;
  logic oe_n = 1, ext = 0, pv = 1, unst = 0;
  logic [9:0] line = 10'h0, vf = 10'h14, vl = 10'h28;
  logic [4:0] burst = 5'h1f;
  vdec_ctrl_pkg::pixel_s pix = '0;
  vdec_ctrl_pkg::proc_settings_s st;
  logic scl, hsda, sda_oe, gp_o, gp_oe, frc, pal_o, fid_o, yoe, soe, coe;
  logic [7:0] luma, chroma, nacks, r;
  wire logic sda_w = hsda & ~sda_oe;
  // Model image, index order 03 06 07 08 09 0a 0b 0c 18 19
  logic [7:0] mdl [10] = vdec_ctrl_pkg::REG_RST;
  logic [3:0] dly [5] = '{4'h0, 4'h7, 4'h8, 4'hb, 4'hf};
  logic [31:0] seed = 32'h58be;
  int failures = 0, checked = 0;
  always #10 clk_i = ~clk_i;
  video_decoder_control_regs dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe),
    .general_purpose_control_pin_i(gp_pin), .general_purpose_control_pin_o(gp_o),
    .general_purpose_control_pin_oe_o(gp_oe), .force_nominal_o(frc), .line_num_i(line),
    .vbi_first_line_i(vf), .vbi_last_line_i(vl), .pal_flag_i(pal), .field_id_i(field_identifier_pin),
    .horizontal_lock_flag_i(horizontal_lock_flag), .vertical_lock_flag_i(vertical_lock_flag), .pal_standard_flag_pin_o(pal_o),
    .field_identifier_pin_o(fid_o), .output_enable_pin_n_i(oe_n), .yuv_enable_ext_i(ext),
    .pix_i(pix), .pix_valid_i(pv), .luma_output_bus_o(luma), .chroma_output_bus_o(chroma),
    .yuv_oe_o(yoe), .sync_oe_o(soe), .clock_oe_o(coe), .burst_level_i(burst),
    .sync_unstable_i(unst), .settings_o(st)
  );
  host_model host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(hsda), .nack_o(nacks));
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  task automatic end_sim();
    if (failures == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input int i, input logic [7:0] d);
    host.wr(vdec_ctrl_pkg::REG_OFS[i], d);
    mdl[i] = d & vdec_ctrl_pkg::REG_MASK[i];
  endtask
  task automatic chk_reg(input int i);
    host.rd(vdec_ctrl_pkg::REG_OFS[i], r);
    cmp(r, mdl[i]);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  // Enable toggles so only half the cycles advance the pixel path
  task automatic feed(input int n, input logic [15:0] p);
    repeat (n) begin
      @(posedge clk_i);
      pix <= p;
      pv <= ~pv;
    end
    @(negedge clk_i);
  endtask
  task automatic step(output int nl, output int nc);
    nl = 0;
    nc = 0;
    @(posedge clk_i);
    pv <= 1;
    pix <= '0;
    repeat (20) @(posedge clk_i);
    pix <= 16'h5a3c;
    for (int k = 1; k < 40; k++) begin
      @(negedge clk_i);
      if (nl == 0 && luma === 8'h5a) nl = k;
      if (nc == 0 && chroma === 8'h3c) nc = k;
    end
  endtask
  initial begin
    repeat (90000) @(posedge clk_i);
    failures++;
    end_sim();
  end
  initial begin
    int t, m, e, nl, nc;
    repeat (20) @(posedge clk_i);
    nrst_i <= 1;
    tick(3);
    foreach (mdl[i]) chk_reg(i);
    host.wr(8'h05, rnd());
    host.rd(8'h05, r);
    cmp(r, 8'h00);
    foreach (mdl[i]) wr(i, rnd());
    foreach (mdl[i]) chk_reg(i);
    tick(1);
    cmp(st.brightness, mdl[4]);
    cmp(st.saturation, mdl[5]);
    cmp(st.hue, mdl[6]);
    cmp(st.contrast, mdl[7]);
    cmp({2'h0, st.coring, st.peak_gain, st.peak_freq}, mdl[3] & 8'h3f);
    wr(8, 8'h05);
    wr(9, 8'hfe);
    for (m = 0; m < 8; m++) begin
      @(posedge clk_i);
      {pal, unst} <= {m[0] & m[1], m[0] & ~m[1]};
      wr(3, {m[2:1], 6'h00});
      tick(1);
      e = m[2:1] == 2 || (m[2:1] < 2 && m[0]);
      cmp({6'h0, st.notch_on, st.comb_on}, e ? 8'h02 : 8'h01);
    end
    for (m = 0; m < 4; m++) begin
      wr(0, {m[1:0], 6'h01});
      tick(2);
      cmp({6'h0, gp_oe, gp_oe & gp_o}, {6'h0, m != 3, m == 1});
    end
    @(posedge clk_i);
    gp_pin <= 1;
    tick(3);
    cmp(8'(frc), 8'h01);
    gp_pin <= 0;
    tick(3);
    cmp(8'(frc), 8'h00);
    wr(0, 8'h83);
    wr(2, 8'h10);
    wr(1, 8'h70);
    // Window is 25 to 38 after the start and end offsets
    for (m = 0; m < 4; m++) begin
      @(posedge clk_i);
      line <= m[1] ? 10'(36 + m) : 10'(24 + m);
      feed(24, 16'h113c);
      e = m == 1 || m == 2;
      cmp(8'(gp_o), 8'(e));
      cmp(chroma, e ? 8'h80 : 8'h3c);
      cmp({6'h0, st.notch_on, st.comb_on}, e ? 8'h00 : 8'h01);
    end
    wr(0, 8'h81);
    @(posedge clk_i);
    line <= 10'd30;
    tick(2);
    cmp(8'(gp_o), 8'h00);
    wr(2, 8'h00);
    for (m = 0; m < 8; m++) begin
      t = rnd() % 31 + 1;
      wr(1, {1'b0, m[2:1], 5'(t)});
      @(posedge clk_i);
      burst <= 5'(t - m[0]);
      feed(24, 16'h113c);
      e = m[2:1] == 2 || (m[2:1] == 0 && m[0]);
      cmp(chroma, e ? 8'h80 : 8'h3c);
    end
    foreach (dly[i]) begin
      wr(2, {1'b0, i[0], 2'b00, dly[i]});
      step(nl, nc);
      cmp(8'(nl - nc), 8'(dly[i] < 8 ? dly[i] : 7 - dly[i]));
      cmp(8'(st.pedestal_absent), 8'(i[0]));
    end
    for (m = 0; m < 8; m++) begin
      wr(0, {2'b00, m[0], m[0], m[0], 2'b00, ~m[0]});
      @(posedge clk_i);
      oe_n <= m[1];
      ext <= m[2];
      {pal, field_identifier_pin, horizontal_lock_flag, vertical_lock_flag} <= 4'(rnd());
      tick(3);
      cmp(8'(yoe), 8'(!m[1] && m[0] && m[2]));
      cmp({6'h0, soe, coe}, {6'h0, m[0], !m[0]});
      cmp({6'h0, pal_o, fid_o}, m[0] ? {6'h0, horizontal_lock_flag, vertical_lock_flag} : {6'h0, pal, field_identifier_pin});
    end
    cmp(nacks, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire

// File: test/vdec_ctrl_chk.sv
// Assertions on the pins and settings of the control bank
`default_nettype none
module vdec_ctrl_chk (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic general_purpose_control_pin_i,
  input wire logic general_purpose_control_pin_oe_o,
  input wire logic force_nominal_o,
  input wire logic pal_flag_i,
  input wire logic field_id_i,
  input wire logic horizontal_lock_flag_i,
  input wire logic vertical_lock_flag_i,
  input wire logic pal_standard_flag_pin_o,
  input wire logic field_identifier_pin_o,
  input wire logic output_enable_pin_n_i,
  input wire logic yuv_enable_ext_i,
  input wire logic pix_valid_i,
  input wire logic [7:0] luma_output_bus_o,
  input wire logic yuv_oe_o,
  input wire logic sync_oe_o,
  input wire logic clock_oe_o,
  input wire vdec_ctrl_pkg::proc_settings_s settings_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_rel;
    $rose(nrst_i);
  endsequence
  sequence s_run;
    $past(nrst_i);
  endsequence
  a_yuv_gate: assert property (
    yuv_oe_o |-> !$past(output_enable_pin_n_i, 2) && yuv_enable_ext_i
  ) else $error("pixel buses driven without all enables");
  a_sync_lock_force: assert property (
    force_nominal_o == (!general_purpose_control_pin_oe_o && $past(general_purpose_control_pin_i, 2))
  ) else $error("nominal hold does not follow sync lock input");
  a_pal_pin_src: assert property (
    s_run ##0 $past(pal_flag_i) == $past(horizontal_lock_flag_i)
      |-> pal_standard_flag_pin_o == $past(pal_flag_i)
  ) else $error("first indicator pin wrong");
  a_fid_pin_src: assert property (
    s_run ##0 $past(field_id_i) == $past(vertical_lock_flag_i)
      |-> field_identifier_pin_o == $past(field_id_i)
  ) else $error("second indicator pin wrong");
  a_oe_reset_vals: assert property (
    s_rel |-> clock_oe_o && !sync_oe_o && !yuv_oe_o
  ) else $error("output enables wrong after reset");
  a_level_reset_vals: assert property (
    s_rel |-> settings_o.brightness == 8'h80 && settings_o.saturation == 8'h80
      && settings_o.contrast == 8'h80 && settings_o.hue == 8'h00 && !settings_o.pedestal_absent
      && settings_o.coring == 2'h0 && settings_o.peak_gain == 2'h0
  ) else $error("settings wrong after reset");
  a_one_luma_filter: assert property (
    !(settings_o.comb_on && settings_o.notch_on)
  ) else $error("trap and comb both selected");
  a_luma_holds: assert property (
    s_run ##0 !$past(pix_valid_i) |-> $stable(luma_output_bus_o)
  ) else $error("luma moved without pixel enable");
endmodule
bind video_decoder_control_regs vdec_ctrl_chk chk (
  .clk_i, .nrst_i, .general_purpose_control_pin_i, .general_purpose_control_pin_oe_o,
  .force_nominal_o, .pal_flag_i, .field_id_i, .horizontal_lock_flag_i, .vertical_lock_flag_i,
  .pal_standard_flag_pin_o, .field_identifier_pin_o, .output_enable_pin_n_i, .yuv_enable_ext_i,
  .pix_valid_i, .luma_output_bus_o, .yuv_oe_o, .sync_oe_o, .clock_oe_o, .settings_o
);
`default_nettype wire

// File: test/vdec_host_model.sv
// Serial host model that reaches the control registers
`default_nettype none
module host_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input wire logic clk_i,
  input wire logic sda_i,
  output var logic scl_o,
  output var logic sda_o,
  output var logic [7:0] nack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1;
    sda_o = 1;
    nack_o = 0;
  end
  // Each phase holds seven clocks, enough for the two-stage synchroniser
  task automatic put(input logic s, input logic c);
    @(posedge clk_i);
    sda_o <= s;
    scl_o <= c;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic bit_io(input logic b, output logic r);
    put(b, 0);
    put(b, 1);
    r = sda_i;
    put(b, 0);
  endtask
  task automatic byte_io(input logic [7:0] b, input logic chk, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(1'b1, a);
    if (chk && a) nack_o <= nack_o + 8'h01;
  endtask
  task automatic start();
    put(1, 0);
    put(1, 1);
    put(0, 1);
    put(0, 0);
  endtask
  task automatic stop();
    put(0, 0);
    put(0, 1);
    put(1, 1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    start();
    byte_io({ADDR, 1'b0}, 1, r);
    byte_io(a, 1, r);
    byte_io(d, 1, r);
    stop();
  endtask
  // Read sets the pointer by a write, then turns round with a repeated start
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] r;
    start();
    byte_io({ADDR, 1'b0}, 1, r);
    byte_io(a, 1, r);
    start();
    byte_io({ADDR, 1'b1}, 1, r);
    byte_io(8'hff, 0, d);
    stop();
  endtask
endmodule
`default_nettype wire
